// *** include/ssim_defines.vh ***
// Constants shared by the sleep sync and indirect messaging block.
`ifndef SSIM_DEFINES_VH
`define SSIM_DEFINES_VH
// Register offsets, word index on the plain register port.
`define SSIM_REG_CTRL   4'h0
`define SSIM_REG_SP     4'h1
`define SSIM_REG_ST     4'h2
`define SSIM_REG_DEST   4'h3
`define SSIM_REG_OWN    4'h4
`define SSIM_REG_STAT   4'h5
// Control bit positions.
`define SSIM_C_INDCOORD 0
`define SSIM_C_POLLER   1
`define SSIM_C_API      2
`define SSIM_C_HWFLOW   3
`define SSIM_C_LOWRATE  4
`define SSIM_C_PREFCRD  5
`define SSIM_C_NONCRD   6
`define SSIM_C_DEPLOY   7
`define SSIM_C_ASLEEP   8
`define SSIM_C_SYNCSLP  9
`define SSIM_C_ROUTER   10
`define SSIM_C_EARLY    11
// Reset values.
`define SSIM_CTRL_RST   12'h880
`define SSIM_SP_RST     16'h0064
`define SSIM_ST_RST     16'h0032
// Message kinds on the host and radio ports.
`define SSIM_K_UNI      3'h0
`define SSIM_K_BCAST    3'h1
`define SSIM_K_DIRBC    3'h2
`define SSIM_K_REPEAT   3'h3
`define SSIM_K_MESH     3'h4
`define SSIM_K_POLL     3'h5
`define SSIM_K_SYNC     3'h6
`define SSIM_K_SREQ     3'h7
// Transmit status code for a purged indirect packet.
`define SSIM_ST_PURGED  8'h75
// Timing: clock rate, millisecond tick length, periods in ms and missed-sync limits.
`define SSIM_CLK_MHZ    50
`define SSIM_TICK_US    1000
`define SSIM_POLL_HI_MS 16'h0064
`define SSIM_POLL_LO_MS 16'h012C
`define SSIM_DEPLOY_MS  16'h000A
`define SSIM_RELAY_MS   16'h0014
`define SSIM_MISS_REQ   4'h6
`define SSIM_MISS_TAKE  4'h3
`endif

// *** core/ssim_squeue.v ***
// Serial input queue holding host transmit requests in arrival order.
`timescale 1ns/1ps
`default_nettype none
module ssim_squeue #(
  parameter DW    = 8,
  parameter DEPTH = 8,
  parameter PW    = 3
) (
  input  wire          mclk,
  input  wire          rst,
  input  wire          push,
  input  wire [DW-1:0] wdata,
  input  wire          pop,
  output wire [DW-1:0] rdata,
  output reg           nempty_q,
  output reg           full_q
);
  reg [DW-1:0] mem_q [0:DEPTH-1];
  reg [PW-1:0] rd_q;
  reg [PW-1:0] wr_q;
  reg [PW:0]   cnt_q;
  wire         do_push;
  wire         do_pop;
  wire [PW:0]  cnt_d;

  // Refuse a push when full so a stalled head never loses a request.
  assign do_push = push && !full_q;
  assign do_pop  = pop && nempty_q;
  assign cnt_d   = cnt_q + {{PW{1'b0}}, do_push} - {{PW{1'b0}}, do_pop};
  assign rdata   = mem_q[rd_q];

  // Pointers wrap at DEPTH, which need not be a power of two.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rd_q     <= {PW{1'b0}};
      wr_q     <= {PW{1'b0}};
      cnt_q    <= {(PW+1){1'b0}};
      nempty_q <= 1'b0;
      full_q   <= 1'b0;
    end
    else
    begin
      if (do_push)
        wr_q <= (wr_q == DEPTH - 1) ? {PW{1'b0}} : wr_q + 1'b1;
      if (do_pop)
        rd_q <= (rd_q == DEPTH - 1) ? {PW{1'b0}} : rd_q + 1'b1;
      cnt_q    <= cnt_d;
      nempty_q <= (cnt_d != {(PW+1){1'b0}});
      full_q   <= (cnt_d == DEPTH);
    end
  end

  // Storage needs no reset; only written slots are ever read.
  always @(posedge mclk)
  begin
    if (do_push)
      mem_q[wr_q] <= wdata;
  end
endmodule // ssim_squeue
`default_nettype wire

// *** core/ssim_core.v ***
// Indirect message queue, poller and sleep synchronisation engine.
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ssim_defines.vh"
module ssim_core #(
  parameter NBUF   = 4,
  parameter QDEPTH = 8,
  parameter AW     = 16,
  parameter MS_CYC = `SSIM_TICK_US * `SSIM_CLK_MHZ
) (
  input  wire          mclk,
  input  wire          rst,
  input  wire [3:0]    reg_addr,
  input  wire [15:0]   reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [15:0]   reg_rdata_q,
  input  wire          hreq_valid,
  input  wire [2:0]    hreq_kind,
  input  wire [AW-1:0] hreq_dest,
  input  wire [7:0]    hreq_tag,
  output reg           hreq_ready_q,
  output reg           cts_n_q,
  output reg           stat_valid_q,
  output reg  [7:0]    stat_code_q,
  output reg  [7:0]    stat_tag_q,
  input  wire          awake_in,
  input  wire          rx_valid,
  input  wire [2:0]    rx_kind,
  input  wire [AW-1:0] rx_src,
  input  wire [AW-1:0] rx_dest,
  input  wire [15:0]   rx_wake,
  input  wire [15:0]   rx_sleep,
  input  wire          rx_deploy,
  output reg           tx_valid_q,
  output reg  [2:0]    tx_kind_q,
  output reg  [AW-1:0] tx_dest_q,
  output reg  [7:0]    tx_tag_q,
  output reg  [15:0]   tx_wake_q,
  output reg  [15:0]   tx_sleep_q,
  output reg           tx_deploy_q,
  output reg           awake_q
);
  localparam QW = 3 + AW + 8;
  localparam S_NONE = 3'h0;
  localparam S_DLV  = 3'h1;
  localparam S_CORR = 3'h2;
  localparam S_SYNC = 3'h3;
  localparam S_RLY  = 3'h4;
  localparam S_SREQ = 3'h5;
  localparam S_POLL = 3'h6;
  localparam S_DIR  = 3'h7;

  // Configuration and settings written by software.
  reg  [11:0]    cfg_q;
  reg  [15:0]    sp_q;
  reg  [15:0]    st_q;
  reg  [AW-1:0]  dest_q;
  reg  [AW-1:0]  own_q;
  // Millisecond tick, buffers and queue.
  reg  [31:0]    pre_q;
  wire           tick;
  reg  [NBUF-1:0] b_vld_q;
  reg  [AW-1:0]  b_dest_q [0:NBUF-1];
  reg  [7:0]     b_tag_q  [0:NBUF-1];
  reg  [23:0]    b_age_q  [0:NBUF-1];
  wire [NBUF-1:0] b_old;
  wire [NBUF-1:0] b_match;
  wire [QW-1:0]  q_rdata;
  wire           q_nempty;
  wire           q_full;
  wire [2:0]     q_kind;
  wire           q_pop;
  // Poll and sync state.
  reg            dlv_pend_q;
  reg  [AW-1:0]  dlv_src_q;
  reg  [15:0]    poll_cnt_q;
  reg            awake_d1_q;
  reg            pend_poll_q;
  reg            pend_sync_q;
  reg            pend_rly_q;
  reg            pend_corr_q;
  reg            pend_sreq_q;
  reg  [AW-1:0]  corr_dst_q;
  reg            wake_ph_q;
  reg  [15:0]    ph_cnt_q;
  reg  [15:0]    wake_dur_q;
  reg  [15:0]    sleep_dur_q;
  reg            synced_q;
  reg            heard_q;
  reg  [3:0]     missed_q;
  reg            coord_q;
  reg            deploy_q;
  reg            relay_q;
  reg            resent_q;
  reg  [15:0]    dep_cnt_q;
  // Arbiter and search results.
  reg  [2:0]     sel;
  reg            any_free;
  reg  [1:0]     free_idx;
  reg            any_old;
  reg  [1:0]     old_idx;
  reg            any_match;
  reg  [1:0]     match_idx;
  wire           ind_coord;
  wire           accept_ind;
  wire           do_purge;
  wire           coord;
  wire           poll_awake;
  wire [15:0]    poll_lim;
  wire [18:0]    purge_lim;
  wire [2:0]     miss3;
  wire [14:0]    shrink;
  wire [15:0]    sleep_eff;
  wire           ph_done;
  wire           wake_start;
  wire           rx_sync;
  wire           own_relay;
  wire           adopt;
  wire           reject;

  assign tick       = (pre_q == MS_CYC - 1);
  assign ind_coord  = cfg_q[`SSIM_C_INDCOORD];
  assign coord      = cfg_q[`SSIM_C_PREFCRD] | coord_q;
  assign q_kind     = q_rdata[QW-1:QW-3];
  assign purge_lim  = {1'b0, sp_q, 2'b00} + {3'b000, sp_q};
  // Only a point-to-multipoint unicast may wait in a buffer.
  assign accept_ind = q_nempty && ind_coord && (q_kind == `SSIM_K_UNI)
                      && any_free;
  assign q_pop      = accept_ind || (sel == S_DIR);
  // Delivery wins a tie so a packet is never both sent and reported.
  assign do_purge   = any_old && !(sel == S_DLV && match_idx == old_idx);

  // Serial queue between the host and the buffers.
  ssim_squeue #(.DW(QW), .DEPTH(QDEPTH), .PW(3)) u_squeue (
    .mclk     (mclk),
    .rst      (rst),
    .push     (hreq_valid),
    .wdata    ({hreq_kind, hreq_dest, hreq_tag}),
    .pop      (q_pop),
    .rdata    (q_rdata),
    .nempty_q (q_nempty),
    .full_q   (q_full)
  );

  // One entry per buffer: hold, age, and free on delivery or purge.
  genvar gi;
  generate
    for (gi = 0; gi < NBUF; gi = gi + 1)
    begin : g_buf
      assign b_old[gi]   = b_vld_q[gi] &&
                           ({b_age_q[gi], 1'b0} > {6'h00, purge_lim});
      assign b_match[gi] = b_vld_q[gi] && (b_dest_q[gi] == dlv_src_q);
      always @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          b_vld_q[gi]  <= 1'b0;
          b_dest_q[gi] <= {AW{1'b0}};
          b_tag_q[gi]  <= 8'h00;
          b_age_q[gi]  <= 24'h000000;
        end
        else if (accept_ind && free_idx == gi)
        begin
          b_vld_q[gi]  <= 1'b1;
          b_dest_q[gi] <= q_rdata[AW+7:8];
          b_tag_q[gi]  <= q_rdata[7:0];
          b_age_q[gi]  <= 24'h000000;
        end
        else if ((sel == S_DLV && match_idx == gi) ||
                 (do_purge && old_idx == gi))
        begin
          b_vld_q[gi] <= 1'b0;
          b_age_q[gi] <= 24'h000000;
        end
        else if (b_vld_q[gi] && tick && b_age_q[gi] != 24'hFFFFFF)
          b_age_q[gi] <= b_age_q[gi] + 24'h000001;
      end
    end
  endgenerate

  // Lowest-index search for a free, an expired and a matching entry.
  integer i;
  always @*
  begin
    any_free  = 1'b0;
    free_idx  = 2'd0;
    any_old   = 1'b0;
    old_idx   = 2'd0;
    any_match = 1'b0;
    match_idx = 2'd0;
    for (i = NBUF - 1; i >= 0; i = i - 1)
    begin
      if (!b_vld_q[i])
      begin
        any_free = 1'b1;
        free_idx = i[1:0];
      end
      if (b_old[i])
      begin
        any_old = 1'b1;
        old_idx = i[1:0];
      end
      if (b_match[i])
      begin
        any_match = 1'b1;
        match_idx = i[1:0];
      end
    end
  end

  // One radio transmission per cycle, most urgent first.
  always @*
  begin
    sel = S_NONE;
    if (dlv_pend_q && any_match)
      sel = S_DLV;
    else if (pend_corr_q)
      sel = S_CORR;
    else if (pend_sync_q)
      sel = S_SYNC;
    else if (pend_rly_q)
      sel = S_RLY;
    else if (pend_sreq_q)
      sel = S_SREQ;
    else if (pend_poll_q)
      sel = S_POLL;
    else if (q_nempty && !(ind_coord && q_kind == `SSIM_K_UNI))
      sel = S_DIR;
  end

  // Sleep cycle timing, with the sleep shortened per missed sync.
  assign miss3      = (missed_q > 4'h7) ? 3'h7 : missed_q[2:0];
  assign shrink     = sleep_dur_q[15:4] * miss3;
  assign sleep_eff  = (cfg_q[`SSIM_C_EARLY] && !coord)
                      ? sleep_dur_q - {1'b0, shrink}
                      : sleep_dur_q;
  assign ph_done    = wake_ph_q ? (ph_cnt_q + 16'h0001 >= wake_dur_q)
                                : (ph_cnt_q + 16'h0001 >= sleep_eff);
  assign rx_sync    = rx_valid && rx_kind == `SSIM_K_SYNC &&
                      cfg_q[`SSIM_C_SYNCSLP];
  assign own_relay  = rx_sync && coord && rx_dest == own_q;
  assign reject     = rx_sync && !coord && !deploy_q && rx_deploy
                      && synced_q;
  assign adopt      = rx_sync && !coord && !reject;
  assign wake_start = cfg_q[`SSIM_C_SYNCSLP] && tick && !wake_ph_q &&
                      ph_done && !adopt;

  // Polling timer: deadline depends on the configured data rate.
  assign poll_awake = cfg_q[`SSIM_C_ASLEEP] ? awake_in : 1'b1;
  assign poll_lim   = cfg_q[`SSIM_C_LOWRATE] ? `SSIM_POLL_LO_MS
                                             : `SSIM_POLL_HI_MS;

  // Register writes; sleep and wake settings feed the network only at wake start.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q  <= `SSIM_CTRL_RST;
      sp_q   <= `SSIM_SP_RST;
      st_q   <= `SSIM_ST_RST;
      dest_q <= {AW{1'b0}};
      own_q  <= {AW{1'b0}};
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SSIM_REG_CTRL: cfg_q  <= reg_wdata[11:0];
        `SSIM_REG_SP:   sp_q   <= reg_wdata;
        `SSIM_REG_ST:   st_q   <= reg_wdata;
        `SSIM_REG_DEST: dest_q <= reg_wdata[AW-1:0];
        `SSIM_REG_OWN:  own_q  <= reg_wdata[AW-1:0];
        default:        cfg_q  <= cfg_q;
      endcase
    end
  end

  // Read data stands in the cycle after the strobe; unmapped read zero.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      reg_rdata_q <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SSIM_REG_CTRL: reg_rdata_q <= {4'h0, cfg_q};
        `SSIM_REG_SP:   reg_rdata_q <= sp_q;
        `SSIM_REG_ST:   reg_rdata_q <= st_q;
        `SSIM_REG_DEST: reg_rdata_q <= dest_q;
        `SSIM_REG_OWN:  reg_rdata_q <= own_q;
        `SSIM_REG_STAT: reg_rdata_q <= {b_vld_q, missed_q, 3'h0, q_full,
                                        wake_ph_q, deploy_q, coord, synced_q};
        default:        reg_rdata_q <= 16'h0000;
      endcase
    end
    else
      reg_rdata_q <= 16'h0000;
  end

  // Host side outputs, radio transmit and purge status registers.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pre_q        <= 32'h00000000;
      hreq_ready_q <= 1'b0;
      cts_n_q      <= 1'b0;
      stat_valid_q <= 1'b0;
      stat_code_q  <= 8'h00;
      stat_tag_q   <= 8'h00;
      tx_valid_q   <= 1'b0;
      tx_kind_q    <= 3'h0;
      tx_dest_q    <= {AW{1'b0}};
      tx_tag_q     <= 8'h00;
      tx_wake_q    <= 16'h0000;
      tx_sleep_q   <= 16'h0000;
      tx_deploy_q  <= 1'b0;
      awake_q      <= 1'b1;
    end
    else
    begin
      pre_q        <= tick ? 32'h00000000 : pre_q + 32'h00000001;
      hreq_ready_q <= !q_full;
      // Requests stay queued while buffers are full; flow stops at full.
      cts_n_q      <= cfg_q[`SSIM_C_HWFLOW] && q_full;
      stat_valid_q <= do_purge && cfg_q[`SSIM_C_API];
      stat_code_q  <= `SSIM_ST_PURGED;
      stat_tag_q   <= b_tag_q[old_idx];
      awake_q      <= wake_ph_q;
      tx_valid_q   <= (sel != S_NONE);
      tx_tag_q     <= 8'h00;
      tx_wake_q    <= wake_dur_q;
      tx_sleep_q   <= sleep_dur_q;
      tx_deploy_q  <= 1'b0;
      tx_dest_q    <= own_q;
      tx_kind_q    <= `SSIM_K_SYNC;
      case (sel)
        S_DLV:
        begin
          tx_kind_q <= `SSIM_K_UNI;
          tx_dest_q <= dlv_src_q;
          tx_tag_q  <= b_tag_q[match_idx];
        end
        S_CORR:   tx_dest_q   <= corr_dst_q;
        S_SYNC:   tx_deploy_q <= deploy_q;
        S_RLY:    tx_dest_q   <= corr_dst_q;
        S_SREQ:   tx_kind_q   <= `SSIM_K_SREQ;
        S_POLL:
        begin
          tx_kind_q <= `SSIM_K_POLL;
          tx_dest_q <= dest_q;
        end
        S_DIR:
        begin
          tx_kind_q <= q_kind;
          tx_dest_q <= q_rdata[AW+7:8];
          tx_tag_q  <= q_rdata[7:0];
        end
        default:  tx_kind_q <= `SSIM_K_SYNC;
      endcase
    end
  end

  // Poll triggers: latch the poller, time regular polls, wake-up poll.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      dlv_pend_q  <= 1'b0;
      dlv_src_q   <= {AW{1'b0}};
      poll_cnt_q  <= 16'h0000;
      awake_d1_q  <= 1'b0;
      pend_poll_q <= 1'b0;
    end
    else
    begin
      // A search that finds nothing for the poller simply ends.
      dlv_pend_q <= 1'b0;
      if (ind_coord && rx_valid && rx_dest == own_q &&
          (rx_kind == `SSIM_K_POLL || rx_kind == `SSIM_K_UNI))
      begin
        dlv_pend_q <= 1'b1;
        dlv_src_q  <= rx_src;
      end
      awake_d1_q <= poll_awake;
      if (sel == S_POLL)
        pend_poll_q <= 1'b0;
      if (!cfg_q[`SSIM_C_POLLER] || !poll_awake)
        poll_cnt_q <= 16'h0000;
      else if (poll_awake && !awake_d1_q)
      begin
        pend_poll_q <= 1'b1;
        poll_cnt_q  <= 16'h0000;
      end
      else if (tick)
      begin
        if (poll_cnt_q + 16'h0001 >= poll_lim)
        begin
          pend_poll_q <= 1'b1;
          poll_cnt_q  <= 16'h0000;
        end
        else
          poll_cnt_q <= poll_cnt_q + 16'h0001;
      end
    end
  end

  // Sleep synchronisation: cycle phase, coordinator duties and sync.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pend_sync_q <= 1'b0;
      pend_rly_q  <= 1'b0;
      pend_corr_q <= 1'b0;
      pend_sreq_q <= 1'b0;
      corr_dst_q  <= {AW{1'b0}};
      wake_ph_q   <= 1'b1;
      ph_cnt_q    <= 16'h0000;
      wake_dur_q  <= `SSIM_ST_RST;
      sleep_dur_q <= `SSIM_SP_RST;
      synced_q    <= 1'b0;
      heard_q     <= 1'b0;
      missed_q    <= 4'h0;
      coord_q     <= 1'b0;
      deploy_q    <= 1'b1;
      relay_q     <= 1'b0;
      resent_q    <= 1'b0;
      dep_cnt_q   <= 16'h0000;
    end
    else
    begin
      // Clears first so that a new request in the same cycle wins.
      if (sel == S_SYNC) pend_sync_q <= 1'b0;
      if (sel == S_RLY)  pend_rly_q  <= 1'b0;
      if (sel == S_CORR) pend_corr_q <= 1'b0;
      if (sel == S_SREQ) pend_sreq_q <= 1'b0;
      if (!cfg_q[`SSIM_C_DEPLOY])
        deploy_q <= 1'b0;
      if (!cfg_q[`SSIM_C_SYNCSLP])
      begin
        wake_ph_q <= 1'b1;
        ph_cnt_q  <= 16'h0000;
      end
      else if (adopt)
      begin
        wake_dur_q  <= rx_wake;
        sleep_dur_q <= rx_sleep;
        wake_ph_q   <= 1'b1;
        ph_cnt_q    <= 16'h0000;
        synced_q    <= 1'b1;
        heard_q     <= 1'b1;
        missed_q    <= 4'h0;
        deploy_q    <= 1'b0;
        corr_dst_q  <= rx_dest;
        if (cfg_q[`SSIM_C_ROUTER])
          pend_rly_q <= 1'b1;
      end
      else if (tick)
      begin
        wake_ph_q <= ph_done ? !wake_ph_q : wake_ph_q;
        ph_cnt_q  <= ph_done ? 16'h0000 : ph_cnt_q + 16'h0001;
        if (wake_ph_q && ph_done && !coord)
        begin
          heard_q <= 1'b0;
          if (!heard_q && missed_q != 4'hF)
            missed_q <= missed_q + 4'h1;
        end
      end
      if (reject)
      begin
        pend_corr_q <= 1'b1;
        corr_dst_q  <= rx_dest;
      end
      if (rx_valid && rx_kind == `SSIM_K_SREQ && synced_q &&
          cfg_q[`SSIM_C_SYNCSLP])
        pend_sync_q <= 1'b1;
      if (own_relay)
      begin
        relay_q  <= 1'b1;
        deploy_q <= 1'b0;
      end
      if (wake_start && coord)
      begin
        wake_dur_q  <= st_q;
        sleep_dur_q <= sp_q;
        pend_sync_q <= 1'b1;
        relay_q     <= 1'b0;
        resent_q    <= 1'b0;
      end
      if (wake_start && !coord)
      begin
        if (!synced_q)
          pend_sreq_q <= 1'b1;
        if (cfg_q[`SSIM_C_NONCRD] && missed_q >= `SSIM_MISS_REQ)
          pend_sreq_q <= 1'b1;
        if (!cfg_q[`SSIM_C_NONCRD] && missed_q >= `SSIM_MISS_TAKE)
        begin
          coord_q     <= 1'b1;
          pend_sync_q <= 1'b1;
        end
      end
      // Deployment bursts until the first relay of our own sync.
      if (coord && deploy_q && tick && cfg_q[`SSIM_C_SYNCSLP])
      begin
        if (dep_cnt_q + 16'h0001 >= `SSIM_DEPLOY_MS)
        begin
          dep_cnt_q   <= 16'h0000;
          pend_sync_q <= 1'b1;
        end
        else
          dep_cnt_q <= dep_cnt_q + 16'h0001;
      end
      if (coord && !deploy_q && wake_ph_q && tick && !relay_q &&
          !resent_q && ph_cnt_q == `SSIM_RELAY_MS)
      begin
        pend_sync_q <= 1'b1;
        resent_q    <= 1'b1;
      end
    end
  end
endmodule // ssim_core
`default_nettype wire

// *** testbench/ssim_chk_assertions.sv ***
// Port checker for the sleep sync and indirect messaging core.
`timescale 1ns/1ps
`default_nettype none
`include "ssim_defines.vh"
module ssim_chk #(
  parameter AW = 16
) (
  input wire logic          mclk,
  input wire logic          rst,
  input wire logic [3:0]    reg_addr,
  input wire logic          reg_rd,
  input wire logic [15:0]   reg_rdata_q,
  input wire logic          hreq_valid,
  input wire logic [2:0]    hreq_kind,
  input wire logic          hreq_ready_q,
  input wire logic          cts_n_q,
  input wire logic          stat_valid_q,
  input wire logic [7:0]    stat_code_q,
  input wire logic          rx_valid,
  input wire logic [AW-1:0] rx_src,
  input wire logic          tx_valid_q,
  input wire logic [2:0]    tx_kind_q,
  input wire logic [AW-1:0] tx_dest_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // A broadcast taken from the host, and a unicast going to the radio.
  sequence bc_req;
    hreq_valid && hreq_ready_q && hreq_kind == `SSIM_K_BCAST;
  endsequence
  sequence uni_out;
    tx_valid_q && tx_kind_q == `SSIM_K_UNI;
  endsequence
  purge_code_a: assert property (stat_valid_q |->
    stat_code_q == `SSIM_ST_PURGED) else $error("bad purge code");
  cts_full_a: assert property (cts_n_q |-> !hreq_ready_q)
    else $error("flow stopped with room left");
  rd_idle_a: assert property (!$past(reg_rd) |->
    reg_rdata_q == 16'h0000) else $error("read data outside slot");
  rd_unmap_a: assert property (reg_rd && reg_addr > `SSIM_REG_STAT
    |=> reg_rdata_q == 16'h0000) else $error("unmapped read not 0");
  poll_hold_a: assert property (uni_out |-> $past(rx_valid, 2))
    else $error("unicast sent without a poll");
  poll_reply_a: assert property (rx_valid ##2 uni_out |->
    tx_dest_q == $past(rx_src, 2)) else $error("reply to wrong node");
  direct_send_a: assert property (bc_req |-> ##[2:40]
    (tx_valid_q && tx_kind_q == `SSIM_K_BCAST)) else $error("no bcast");
  bc_early_a: assert property (bc_req |=>
    !(tx_valid_q && tx_kind_q == `SSIM_K_BCAST)) else $error("too soon");
endmodule // ssim_chk
bind ssim_core ssim_chk #(.AW(AW)) chk (.mclk(mclk), .rst(rst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .hreq_valid(hreq_valid), .hreq_kind(hreq_kind),
  .hreq_ready_q(hreq_ready_q), .cts_n_q(cts_n_q),
  .stat_valid_q(stat_valid_q), .stat_code_q(stat_code_q),
  .rx_valid(rx_valid), .rx_src(rx_src), .tx_valid_q(tx_valid_q),
  .tx_kind_q(tx_kind_q), .tx_dest_q(tx_dest_q));
`default_nettype wire

// *** testbench/ssim_peer.sv ***
// Radio peer model that hands received frames to the core.
`timescale 1ns/1ps
`default_nettype none
module ssim_peer (
  input  wire logic        mclk,
  output var  logic        rx_valid,
  output var  logic [2:0]  rx_kind,
  output var  logic [15:0] rx_src,
  output var  logic [15:0] rx_dest
);
  // After a frame, idle source and destination show flipped copies so stale data is never mistaken.
  initial
  begin
    rx_valid = 1'h0;
    rx_kind = 3'h0;
    rx_src = 16'h0000;
    rx_dest = 16'h0000;
  end
  task send(input logic [2:0] k, input logic [15:0] s, d);
    @(posedge mclk);
    rx_valid <= 1'h1;
    rx_kind <= k;
    rx_src <= s;
    rx_dest <= d;
    @(posedge mclk);
    rx_valid <= 1'h0;
    rx_src <= ~s;
    rx_dest <= ~d;
  endtask
endmodule // ssim_peer
`default_nettype wire

// *** testbench/sleep_sync_indirect_messaging_bench.sv ***
// Self-checking bench for the indirect messaging core.
`timescale 1ns/1ps
`default_nettype none
`include "ssim_defines.vh"
module sleep_sync_indirect_messaging_bench;
  logic        mclk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, hv = 1'h0;
  logic [3:0]  ad = 4'h0;
  logic [15:0] wd = 16'h0000, hd = 16'h0000, tdst, rq, rs, rdst, d;
  logic [2:0]  hk = 3'h0, tk, rk;
  logic [7:0]  ht = 8'h00, sc, st, tt, t;
  logic        hr, cts, sv, tv, rv;
  logic [26:0] exq[$];
  logic        aw = 1'h1, rdp = 1'h0, tdp, aq;
  logic [15:0] rw = 16'h0032, rsl = 16'h0064, tw, ts;
  logic [26:0] exd;
  int          n, k, seed, compares, n_mismatch;
  ssim_core #(.NBUF(4), .QDEPTH(8), .MS_CYC(10)) uut (
    .mclk(mclk), .rst(rst), .reg_addr(ad), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata_q(rq), .hreq_valid(hv),
    .hreq_kind(hk), .hreq_dest(hd), .hreq_tag(ht), .hreq_ready_q(hr),
    .cts_n_q(cts), .stat_valid_q(sv), .stat_code_q(sc),
    .stat_tag_q(st), .awake_in(aw), .rx_valid(rv), .rx_kind(rk),
    .rx_src(rs), .rx_dest(rdst), .rx_wake(rw),
    .rx_sleep(rsl), .rx_deploy(rdp), .tx_valid_q(tv),
    .tx_kind_q(tk), .tx_dest_q(tdst), .tx_tag_q(tt), .tx_wake_q(tw),
    .tx_sleep_q(ts), .tx_deploy_q(tdp), .awake_q(aq));
  ssim_peer peer (.mclk(mclk), .rx_valid(rv), .rx_kind(rk),
    .rx_src(rs), .rx_dest(rdst));
  always #10 mclk = ~mclk;
  task check(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Register cycle; a read compares the word in its one data slot.
  task rg(input logic w, input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    wr <= w;
    rd <= !w;
    ad <= a;
    wd <= v;
    @(posedge mclk);
    wr <= 1'h0;
    rd <= 1'h0;
    #1;
    if (!w) check(rq, v);
  endtask
  // Host request held one edge, then one idle edge as margin.
  task push(input logic [2:0] kd, input logic [15:0] ds, input logic [7:0] tg);
    @(posedge mclk);
    hv <= 1'h1;
    hk <= kd;
    hd <= ds;
    ht <= tg;
    @(posedge mclk);
    hv <= 1'h0;
    @(posedge mclk);
    #1;
  endtask
  // Every data frame sent must match the oldest one the model expects.
  always @(negedge mclk)
    if (tv && tk <= `SSIM_K_MESH)
    begin
      exd = exq.size() ? exq.pop_front() : 27'h0;
      check({tk, tdst, tt}, exd);
    end
  initial
  begin
    #1000000;
    n_mismatch++;
    test_done;
  end
  initial
  begin
    seed = $urandom(51214);
    repeat (16) @(posedge mclk);
    rst <= 1'h0;
    repeat (2) @(posedge mclk);
    rg(0, `SSIM_REG_CTRL, {4'h0, `SSIM_CTRL_RST});
    // Host may push and the node is awake as soon as reset is over.
    check({hr, aq}, 2'h3);
    rg(0, `SSIM_REG_SP, `SSIM_SP_RST);
    rg(0, 4'hF, 16'h0000);
    rg(1, `SSIM_REG_CTRL, 16'h088D);
    rg(1, `SSIM_REG_OWN, 16'h1234);
    for (k = 1; k < 5; k++)
    begin
      t = $urandom;
      d = $urandom;
      exq.push_back({k[2:0], d, t});
      push(k[2:0], d, t);
      repeat (8) @(posedge mclk);
    end
    for (n = 0; n < 20 && !cts; n++)
      push(`SSIM_K_UNI, 16'h0BEE, n[7:0]);
    check(n, 8'h0C);
    for (n = 0; n < 13; n++)
    begin
      // The lowest busy buffer answers first and is refilled at once.
      t = (n == 0) ? 8'h00 : (n < 9) ? n[7:0] + 8'h03 : n[7:0] - 8'h08;
      if (n < 12) exq.push_back({`SSIM_K_UNI, 16'h0BEE, t});
      peer.send(n[0] ? `SSIM_K_UNI : `SSIM_K_POLL, 16'h0BEE, 16'h1234);
      repeat (6) @(posedge mclk);
    end
    check(exq.size(), 8'h00);
    check(cts, 1'h0);
    rg(1, `SSIM_REG_SP, 16'h0004);
    push(`SSIM_K_UNI, 16'h0BEE, 8'hA5);
    for (n = 0; n < 200 && !sv; n++) @(negedge mclk);
    check({sc, st}, 16'h75A5);
    check(n > 95 && n < 130, 1'h1);
    if (!sv) test_done;
    peer.send(`SSIM_K_POLL, 16'h0BEE, 16'h1234);
    repeat (8) @(posedge mclk);
    // A router adopts a sync, relays it and keeps the carried wake time.
    t = $urandom;
    d = $urandom;
    rw <= {14'h0000, t[1:0]} + 16'h0002;
    rsl <= d;
    rg(1, `SSIM_REG_CTRL, 16'h0E8D);
    peer.send(`SSIM_K_SYNC, 16'h0BEE, 16'h0777);
    @(posedge mclk);
    @(negedge mclk);
    check({tv, tdp, tk, tdst}, {2'h2, `SSIM_K_SYNC, 16'h0777});
    check({tw, ts}, {rw, rsl});
    for (n = 0; n < 400 && aq; n++) @(negedge mclk);
    check(n > 10 * rw - 12 && n <= 10 * rw + 2, 1'h1);
    test_done;
  end
endmodule // sleep_sync_indirect_messaging_bench
`default_nettype wire
